// ### bench/vpic_core_model.sv
/* Behavioural core: acks each request and holds ack seven cycles.
   Assumes the bench asks for completion by a pulse on fin. */
`default_nettype none
module vpic_core_model (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic core_irq_req, // Request
  input wire logic [15:0] core_service_addr, // Target
  input wire logic fin, // Routine end asked
  output logic core_request_ack, // Ack level
  output logic service_complete, // Completion pulse
  output logic [15:0] last_addr // Target taken
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  always @(posedge sys_clk) begin
    service_complete <= fin && !rst;
    if (rst) begin
      core_request_ack <= 1'b0;
      last_addr <= 16'h0000;
      cnt <= 0;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      core_request_ack <= cnt > 1;
    end else if (core_irq_req) begin
      core_request_ack <= 1'b1;
      cnt <= 7;
      last_addr <= core_service_addr;
    end
  end
endmodule // vpic_core_model
`default_nettype wire

// ### bench/vpic_ctrl_monitor.sv
/* Port checker for vpic_ctrl.
   Assumes it is bound into vpic_ctrl, one clock. */
`default_nettype none
module vpic_mon #(
  parameter AW = 16
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [31:0] fixed_irq, // Fixed lines
  input wire logic [15:0] dma_term_group_a, // DMA a
  input wire logic [15:0] dma_term_group_b, // DMA b
  input wire logic [31:0] logic_irq, // Logic lines
  input wire logic core_irq_req, // Request
  input wire logic [4:0] core_vector, // Vector
  input wire logic [AW-1:0] core_service_addr, // Target
  input wire logic core_request_ack, // Ack
  input wire logic service_complete, // Done
  input wire logic [3:0] active_level // Level
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_req_hold:
    assert property (core_irq_req && !core_request_ack |=> core_irq_req && $stable(core_vector))
      else $error("request or vector moved before ack");
  chk_ack_take:
    assert property (core_irq_req && core_request_ack
      |=> !core_irq_req && active_level < $past(active_level))
      else $error("ack did not raise level");
  chk_pop_level:
    assert property (service_complete && !core_irq_req && !core_request_ack
      && active_level != 4'h8 |=> active_level > $past(active_level))
      else $error("completion did not restore level");
  chk_eval_gap:
    assert property (!core_request_ack && $past(core_request_ack)
      |-> !core_irq_req ##1 !core_irq_req)
      else $error("request without evaluation time");
  chk_idle_level:
    assert property ($fell(rst) |-> active_level == 4'h8 && !core_irq_req)
      else $error("not idle after reset");
  chk_ready_pulse:
    assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
  chk_write_fast:
    assert property (psel && !penable && pwrite |=> pready)
      else $error("write not answered at once");
  chk_err_misal:
    assert property (psel && !penable && pwrite && paddr[1:0] != 2'h0 |=> pready && pslverr)
      else $error("misaligned write not refused");
  chk_err_ready:
    assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule // vpic_mon

bind vpic_ctrl vpic_mon #(.AW(AW)) vpic_mon_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fixed_irq(fixed_irq), .logic_irq(logic_irq),
  .dma_term_group_a(dma_term_group_a), .dma_term_group_b(dma_term_group_b),
  .core_irq_req(core_irq_req), .core_vector(core_vector), .active_level(active_level),
  .core_service_addr(core_service_addr), .core_request_ack(core_request_ack),
  .service_complete(service_complete));
`default_nettype wire

// ### bench/vpic_ctrl_tb.sv
/* Bench for vpic_ctrl: APB master, sources, core model.
   Assumes vpic_core_model and the bound vpic_mon. */
`default_nettype none
module vpic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} vpic_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fin = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, fixed_irq = 32'h00000000, logic_irq = 32'h00000000;
  logic [15:0] dma_term_group_a = 16'h0000, dma_term_group_b = 16'h0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, core_irq_req, core_request_ack, service_complete, er;
  logic [4:0] core_vector;
  logic [15:0] core_service_addr, last_addr;
  logic [3:0] active_level;
  int n_fail = 0;
  int total_checks = 0;
  int n;
  vpic_row_t rows[9] = '{'{12'h010, 32'hFFFFFFFF, 32'h77777777, 1'b0},
    '{12'h01C, 32'h12345670, 32'h12345670, 1'b0}, '{12'h024, 32'hAAAAAAAA, 32'hAAAAAAAA, 1'b0},
    '{12'h084, 32'h1234ABCD, 32'h0000ABCD, 1'b0}, '{12'h0FC, 32'h0000FFFF, 32'h0000FFFF, 1'b0},
    '{12'h028, 32'hFFFFFFFF, 32'h00000000, 1'b0}, '{12'h030, 32'hFFFFFFFF, 32'h00000000, 1'b1},
    '{12'h102, 32'hFFFFFFFF, 32'h00000000, 1'b1}, '{12'h204, 32'hFFFFFFFF, 32'h00000000, 1'b1}};

  always #50 sys_clk = ~sys_clk;

  vpic_ctrl vpic_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fixed_irq(fixed_irq), .dma_term_group_a(dma_term_group_a),
    .dma_term_group_b(dma_term_group_b), .logic_irq(logic_irq), .core_irq_req(core_irq_req),
    .core_vector(core_vector), .core_service_addr(core_service_addr),
    .core_request_ack(core_request_ack), .service_complete(service_complete),
    .active_level(active_level));
  vpic_core_model vpic_core_model_inst (.sys_clk(sys_clk), .rst(rst), .fin(fin),
    .core_irq_req(core_irq_req), .core_service_addr(core_service_addr),
    .core_request_ack(core_request_ack), .service_complete(service_complete),
    .last_addr(last_addr));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x, input string m);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  // Request held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk) psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk(rd, x, $sformatf("read %h", a));
  endtask
  task wait_req();
    n = 0;
    do @(posedge sys_clk) #1 n++; while (core_irq_req !== 1'b1);
  endtask
  task serve();
    n = 0;
    do @(posedge sys_clk) #1 n++; while (core_request_ack !== 1'b1);
    do @(posedge sys_clk) #1 n++; while (core_request_ack !== 1'b0);
  endtask
  task done_isr();
    @(posedge sys_clk) fin <= 1'b1;
    @(posedge sys_clk) fin <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #300000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(12'h000, 32'h00000000);
    for (int i = 0; i < 4; i++) rdchk(12'(16 + 4 * i), 32'h77777777);
    rdchk(12'h024, 32'h00000000);
    rdchk(12'h00C, 32'h00000008);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(32'(er), 32'(rows[i].e), "write err");
      rdchk(rows[i].a, rows[i].x);
      chk(32'(er), 32'(rows[i].e), "read err");
    end
    $display("test registers done");
    wr(12'h010, 32'h00002000);
    wr(12'h08C, 32'h00003333);
    wr(12'h090, 32'h00004444);
    wr(12'h000, 32'h00000018);
    @(posedge sys_clk) fixed_irq[3] <= 1'b1;
    wait_req();
    chk(32'(n), 32'h00000005, "latency");
    chk(32'(core_vector), 32'h00000003, "vector");
    chk(32'(core_service_addr), 32'h00003333, "target");
    serve();
    chk(32'(last_addr), 32'h00003333, "taken");
    rdchk(12'h00C, 32'h00030012);
    rdchk(12'h004, 32'h00000000);
    rdchk(12'h028, 32'h00000000);
    wr(12'h004, 32'h00000010);
    wait_req();
    chk(32'(core_vector), 32'h00000004, "preempt");
    serve();
    rdchk(12'h00C, 32'h00040020);
    done_isr();
    rdchk(12'h00C, 32'h00040012);
    done_isr();
    rdchk(12'h00C, 32'h00040008);
    $display("test nesting done");
    wr(12'h010, 32'h55002000);
    wr(12'h000, 32'h00000000);
    wr(12'h004, 32'h000002C0);
    rdchk(12'h004, 32'h000002C0);
    rdchk(12'h028, 32'h00000000);
    chk(32'(core_irq_req), 32'h00000000, "disabled");
    wr(12'h008, 32'h00000200);
    rdchk(12'h004, 32'h000000C0);
    wr(12'h000, 32'h000000C0);
    wait_req();
    chk(32'(core_vector), 32'h00000006, "tie");
    serve();
    repeat (6) @(posedge sys_clk);
    chk(32'(core_irq_req), 32'h00000000, "same level");
    done_isr();
    wait_req();
    chk(32'(core_vector), 32'h00000007, "second");
    serve();
    done_isr();
    rdchk(12'h00C, 32'h00070008);
    $display("test tie done");
    wr(12'h000, 32'h00000000);
    wr(12'h020, 32'h00000810);
    wr(12'h024, 32'h00000034);
    @(posedge sys_clk) fixed_irq <= 32'h00060028;
    logic_irq <= 32'h00000020;
    dma_term_group_a <= 16'h0024;
    dma_term_group_b <= 16'h0002;
    repeat (3) @(posedge sys_clk);
    rdchk(12'h004, 32'h00020024);
    $display("test sources done");
    @(posedge sys_clk) rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(12'h00C, 32'h00000008);
    rdchk(12'h004, 32'h00000000);
    $display("test second reset done");
    conclude();
  end
endmodule // vpic_ctrl_tb
`default_nettype wire

// ### pkg/vpic_consts.vh
/*
 * Constants of the vectored priority interrupt controller: register byte
 * offsets, field positions, reset values and encodings.
 * Assumes it is included by bare name from the design files.
 */
`ifndef VPIC_CONSTS_VH
`define VPIC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets (paddr[7:0]; paddr[11:8] must be zero)
// ----------------------------------------------------------------
`define VPIC_OFF_ENABLE 8'h00
`define VPIC_OFF_SETPEND 8'h04
`define VPIC_OFF_CLRPEND 8'h08
`define VPIC_OFF_STATUS 8'h0C
`define VPIC_OFF_PRIO0 8'h10
`define VPIC_OFF_PRIO1 8'h14
`define VPIC_OFF_PRIO2 8'h18
`define VPIC_OFF_PRIO3 8'h1C
`define VPIC_OFF_SRCSEL0 8'h20
`define VPIC_OFF_SRCSEL1 8'h24
`define VPIC_OFF_POSTED 8'h28
`define VPIC_TBL_BIT 7

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define VPIC_RST_ENABLE 32'h00000000
`define VPIC_RST_PRIO 32'h77777777
`define VPIC_PRIO_MASK 32'h77777777
`define VPIC_RST_SRCSEL 32'h00000000
`define VPIC_LVL_NONE 4'h8

// ----------------------------------------------------------------
// Source select codes, two bits per vector
// ----------------------------------------------------------------
`define VPIC_SRC_FIXED 2'h0
`define VPIC_SRC_DMA 2'h1
`define VPIC_SRC_LOGIC 2'h2

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define VPIC_ST_LVL_LSB 0
`define VPIC_ST_DEPTH_LSB 4
`define VPIC_ST_REQ_BIT 8
`define VPIC_ST_VEC_LSB 16

`endif

// ### rtl/vpic_addr_mem.v
/*
 * Service address table: one word per vector, one write port and two
 * registered read ports (bus readback and core vector fetch).
 * Assumes a single clock; contents are not cleared by reset.
 */
`default_nettype none

module vpic_addr_mem #(
  parameter AW = 5,
  parameter DW = 16
) (
  input wire sys_clk, // System clock
  input wire rst, // Sync reset, clears read registers only
  input wire wr_en, // Write strobe
  input wire [AW-1:0] wr_addr, // Write index
  input wire [DW-1:0] wr_data, // Write data
  input wire [AW-1:0] rd_a_addr, // Bus read index
  output reg [DW-1:0] rd_a_data, // Bus read data, registered
  input wire [AW-1:0] rd_b_addr, // Core read index
  output reg [DW-1:0] rd_b_data // Core read data, registered
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      rd_a_data <= {DW{1'b0}};
      rd_b_data <= {DW{1'b0}};
    end else begin
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
    end
  end

endmodule // vpic_addr_mem

`default_nettype wire

// ### rtl/vpic_ctrl.v
/*
 * Vectored priority interrupt controller: 32 vectors with per-vector
 * source select, enable, priority and service address, nesting up to
 * eight deep, APB register access.
 * Assumes sources, core handshake and APB are synchronous to sys_clk.
 *
//Contract
//- Thirty-two vectors, 0 to 31, each with its own service routine.
//- Each vector has a software-writable service address, changeable any time.
//- Each vector has an independent enable.
//- Each vector holds a run-time writable three-bit priority, eight levels.
//- Nesting up to eight deep; higher priority preempts running service.
//- Software raises any vector by a register write.
//- Software clears any pending flag by a register write.
//- Source edge sets pending flag on the next clock edge.
//- Posted flag sets the cycle after pending.
//- Request and vector number reach core after three clocks of evaluation.
//- Winning service address is presented; core acknowledges, then reads it.
//- On acknowledge pending clears first, posted one cycle later.
//- Core drops acknowledge after seven cycles once branching is done.
//- On completion, active level returns to its value before the interrupt.
//- Equal priorities resolve to the lowest vector number.
//- Each vector selects fixed, DMA or logic-array source.
//- DMA inputs are the two termination groups of the DMA channels.
//- Vector n uses DMA group a bit n below 16, else group b bit n-16.
//- Any signal reaches any vector through its logic-array input.
 */
`default_nettype none
`include "vpic_consts.vh"

module vpic_ctrl #(
  parameter NVEC = 32,
  parameter NEST = 8,
  parameter AW = 16
) (
  input wire sys_clk, // System clock, 10 MHz
  input wire rst, // Synchronous reset, active high
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction, high for write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error, unmapped address
  input wire [31:0] fixed_irq, // Fixed-function peripheral lines
  input wire [15:0] dma_term_group_a, // DMA termination group a
  input wire [15:0] dma_term_group_b, // DMA termination group b
  input wire [31:0] logic_irq, // Logic-array lines
  output reg core_irq_req, // Request to core
  output reg [4:0] core_vector, // Winning vector number
  output wire [AW-1:0] core_service_addr, // Winning service address
  input wire core_request_ack, // Core acknowledge, level
  input wire service_complete, // Core completion pulse
  output reg [3:0] active_level // Current active priority, 8 is none
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_EV1 = 5'h02;
  localparam [4:0] ST_EV2 = 5'h04;
  localparam [4:0] ST_REQ = 5'h08;
  localparam [4:0] ST_ACK = 5'h10;

  reg [4:0] state;
  reg [31:0] enable;
  reg [31:0] pending_flag;
  reg [31:0] posted_flag;
  reg [127:0] prio_flat;
  reg [63:0] srcsel_flat;
  reg [31:0] src_prev;
  reg [3:0] lvl_stack [0:NEST-1];
  reg [3:0] depth;
  reg comp_wait;
  reg [4:0] win_vec;
  reg [2:0] win_prio;
  reg tbl_wait;
  reg [31:0] reg_rdata;
  reg reg_hit;
  reg ev_found;
  reg [4:0] ev_vec;
  reg [3:0] ev_best;
  reg [31:0] next_pending;
  reg [31:0] next_posted;
  integer i;

  wire [31:0] src_now;
  wire [AW-1:0] tbl_rdata;
  wire setup = psel & ~penable;
  wire fire = psel & penable & pready;
  wire wr_fire = fire & pwrite & ~pslverr;
  wire upper_ok = (paddr[11:8] == 4'h0) & (paddr[1:0] == 2'h0);
  wire tbl_sel = upper_ok & paddr[`VPIC_TBL_BIT];
  wire [7:0] off = paddr[7:0];
  wire [31:0] cand = posted_flag & enable;
  wire take = (state == ST_REQ) & core_request_ack;

  // ----------------------------------------------------------------
  // Source selection per vector
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NVEC; g = g + 1) begin : g_src
      wire [1:0] sel = srcsel_flat[2*g +: 2];
      // Group a feeds the low half, group b the high half
      wire dma_bit = (g < 16) ? dma_term_group_a[g % 16] :
                     dma_term_group_b[g % 16];
      // Logic-array line n lets any routed signal drive vector n
      assign src_now[g] = (sel == `VPIC_SRC_FIXED) ? fixed_irq[g] :
                          (sel == `VPIC_SRC_DMA) ? dma_bit :
                          (sel == `VPIC_SRC_LOGIC) ? logic_irq[g] : 1'b0;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Service address table
  // ----------------------------------------------------------------
  // Table is not reset; software loads it before enabling vectors
  vpic_addr_mem #(
    .AW(5),
    .DW(AW)
  ) u_tbl (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(wr_fire & tbl_sel),
    .wr_addr(paddr[6:2]),
    .wr_data(pwdata[AW-1:0]),
    .rd_a_addr(paddr[6:2]),
    .rd_a_data(tbl_rdata),
    .rd_b_addr(win_vec),
    .rd_b_data(core_service_addr)
  );

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always @* begin
    reg_rdata = 32'h00000000;
    reg_hit = upper_ok;
    case (off)
      `VPIC_OFF_ENABLE: reg_rdata = enable;
      `VPIC_OFF_SETPEND: reg_rdata = pending_flag;
      `VPIC_OFF_CLRPEND: reg_rdata = pending_flag;
      `VPIC_OFF_POSTED: reg_rdata = posted_flag;
      `VPIC_OFF_STATUS: begin
        reg_rdata[`VPIC_ST_LVL_LSB +: 4] = active_level;
        reg_rdata[`VPIC_ST_DEPTH_LSB +: 4] = depth;
        reg_rdata[`VPIC_ST_REQ_BIT] = core_irq_req;
        reg_rdata[`VPIC_ST_VEC_LSB +: 5] = core_vector;
      end
      `VPIC_OFF_PRIO0: reg_rdata = prio_flat[31:0];
      `VPIC_OFF_PRIO1: reg_rdata = prio_flat[63:32];
      `VPIC_OFF_PRIO2: reg_rdata = prio_flat[95:64];
      `VPIC_OFF_PRIO3: reg_rdata = prio_flat[127:96];
      `VPIC_OFF_SRCSEL0: reg_rdata = srcsel_flat[31:0];
      `VPIC_OFF_SRCSEL1: reg_rdata = srcsel_flat[63:32];
      default: reg_hit = tbl_sel;
    endcase
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Table reads cost one extra wait state, so prdata stays a flop
  always @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tbl_wait <= 1'b0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (setup) begin
        if (tbl_sel && !pwrite) begin
          tbl_wait <= 1'b1;
        end else begin
          pready <= 1'b1;
          pslverr <= ~reg_hit;
          // Writes leave the last read data in place
          if (!pwrite) begin
            prdata <= reg_hit ? reg_rdata : 32'h00000000;
          end
        end
      end else if (psel && penable && tbl_wait) begin
        tbl_wait <= 1'b0;
        pready <= 1'b1;
        prdata <= {{(32-AW){1'b0}}, tbl_rdata};
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      enable <= `VPIC_RST_ENABLE;
      prio_flat <= {4{`VPIC_RST_PRIO}};
      srcsel_flat <= {2{`VPIC_RST_SRCSEL}};
    end else if (wr_fire && !tbl_sel) begin
      // Read-only and unlisted offsets ignore writes
      case (off)
        `VPIC_OFF_ENABLE: enable <= pwdata;
        `VPIC_OFF_PRIO0: prio_flat[31:0] <= pwdata & `VPIC_PRIO_MASK;
        `VPIC_OFF_PRIO1: prio_flat[63:32] <= pwdata & `VPIC_PRIO_MASK;
        `VPIC_OFF_PRIO2: prio_flat[95:64] <= pwdata & `VPIC_PRIO_MASK;
        `VPIC_OFF_PRIO3: prio_flat[127:96] <= pwdata & `VPIC_PRIO_MASK;
        `VPIC_OFF_SRCSEL0: srcsel_flat[31:0] <= pwdata;
        `VPIC_OFF_SRCSEL1: srcsel_flat[63:32] <= pwdata;
        default: enable <= enable;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pending and posted flags
  // ----------------------------------------------------------------
  wire sw_set_hit = wr_fire & ~tbl_sel & (off == `VPIC_OFF_SETPEND);
  wire sw_clr_hit = wr_fire & ~tbl_sel & (off == `VPIC_OFF_CLRPEND);
  wire [31:0] sw_set = sw_set_hit ? pwdata : 32'h00000000;
  wire [31:0] sw_clr = sw_clr_hit ? pwdata : 32'h00000000;
  wire [31:0] win_mask = 32'h00000001 << win_vec;
  wire [31:0] hw_set = src_now & ~src_prev;

  // Setting beats clearing in the same cycle for pending flags; for posted flags the clear wins
  always @* begin
    next_pending = pending_flag & ~sw_clr;
    if (take) begin
      next_pending = next_pending & ~win_mask;
    end
    next_pending = next_pending | hw_set | sw_set;
    next_posted = (posted_flag | (pending_flag & enable)) & ~sw_clr;
    if (state == ST_ACK) begin
      next_posted = next_posted & ~win_mask;
    end
  end

  always @(posedge sys_clk) begin
    // Tracked through reset so a line held high is not taken as a new event
    src_prev <= src_now;
    if (rst) begin
      pending_flag <= 32'h00000000;
      posted_flag <= 32'h00000000;
    end else begin
      pending_flag <= next_pending;
      posted_flag <= next_posted;
    end
  end

  // ----------------------------------------------------------------
  // Priority evaluation
  // ----------------------------------------------------------------
  // Scan from the top with <= so equal levels settle on the lowest vector
  // Only a strictly better level than the active one may preempt
  always @* begin
    ev_found = 1'b0;
    ev_vec = 5'h00;
    ev_best = 4'hF;
    for (i = NVEC - 1; i >= 0; i = i - 1) begin
      if (cand[i] && ({1'b0, prio_flat[4*i +: 3]} < active_level) &&
          ({1'b0, prio_flat[4*i +: 3]} <= ev_best)) begin
        ev_found = 1'b1;
        ev_vec = i[4:0];
        ev_best = {1'b0, prio_flat[4*i +: 3]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Request sequencer and nesting stack
  // ----------------------------------------------------------------
  // Request is held until acknowledged even if a better vector appears
  always @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      core_irq_req <= 1'b0;
      core_vector <= 5'h00;
      win_vec <= 5'h00;
      win_prio <= 3'h0;
      depth <= 4'h0;
      active_level <= `VPIC_LVL_NONE;
      comp_wait <= 1'b0;
    end else begin
      if (service_complete) begin
        comp_wait <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          // Depth guard keeps a ninth push off the level stack
          if (ev_found && depth < NEST) begin
            win_vec <= ev_vec;
            win_prio <= ev_best[2:0];
            state <= ST_EV1;
          end
        end
        ST_EV1: begin
          state <= ST_EV2;
        end
        ST_EV2: begin
          // Drop out if software cleared or disabled the winner meanwhile
          if (cand[win_vec]) begin
            core_irq_req <= 1'b1;
            core_vector <= win_vec;
            state <= ST_REQ;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_REQ: begin
          if (core_request_ack) begin
            core_irq_req <= 1'b0;
            lvl_stack[depth[2:0]] <= active_level;
            depth <= depth + 4'h1;
            active_level <= {1'b0, win_prio};
            state <= ST_ACK;
          end
        end
        ST_ACK: begin
          // Core holds acknowledge while branching; wait for it to drop
          if (!core_request_ack) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // Completion deferred while a new level is being pushed
      if ((service_complete || comp_wait) && !take) begin
        comp_wait <= 1'b0;
        if (depth != 4'h0) begin
          depth <= depth - 4'h1;
          active_level <= lvl_stack[depth[2:0] - 3'h1];
        end
      end
    end
  end

endmodule // vpic_ctrl

`default_nettype wire
